//--- logic/gcf_cfg.svh
// Constants of the commissioning frame builder: field values, byte positions, resets
`ifndef GCF_CFG_SVH
`define GCF_CFG_SVH

// Network header and fixed field values
`define GCF_HDR_LEN 6'd6
`define GCF_FRAME_CTRL 8'h8c
`define GCF_EXT_FRAME_CTRL 8'h30
`define GCF_CMD_COMMISSION 8'he0
`define GCF_CMD_DECOMMISSION 8'he1
`define GCF_DEVID_DEFAULT 8'h07
`define GCF_OPT_APP_INFO 8'h85
`define GCF_OPT_NO_APP_INFO 8'h81
`define GCF_EXT_OPTIONS 8'hf2
`define GCF_AI_TYPE_SWITCH 8'h10
`define GCF_AI_LEN_SWITCH 8'h02
`define GCF_AI_TYPE_CMDLIST 8'h04
`define GCF_SWCFG_DEFAULT 8'h01
`define GCF_CMD_INACTIVE 8'hff
// Entry 0 in the low byte, entry 7 in the high byte
`define GCF_CMD_TABLE_DEFAULT 64'h1716151413122322

// Byte positions of a commissioning frame
`define GCF_IDX_SRC 6'd2
`define GCF_IDX_CMD 6'd6
`define GCF_IDX_DEVID 6'd7
`define GCF_IDX_OPT 6'd8
`define GCF_IDX_EXTOPT 6'd9
`define GCF_IDX_KEY 6'd10
`define GCF_IDX_HASH 6'd26
`define GCF_IDX_SEQ 6'd30
`define GCF_IDX_SEQ_END 6'd33
`define GCF_IDX_AI_TYPE 6'd34
`define GCF_IDX_AI_LEN 6'd35
`define GCF_IDX_SWCFG 6'd36
`define GCF_IDX_CONTACT 6'd37

// Byte positions of a decommissioning frame
`define GCF_DIDX_SEQ 6'd6
`define GCF_DIDX_CMD 6'd10
`define GCF_DIDX_SIG 6'd11
`define GCF_DIDX_LAST 6'd14

// Reset values
`define GCF_SEQ_RST 32'h00000000
`define GCF_KEY2_RST 128'h0
`define GCF_LFSR_SEED 128'h5a3c96e1_0f1e2d3c_4b5a6978_8796a5b4

// Output buffer
`define GCF_FIFO_DEPTH 32
`define GCF_FIFO_WIDTH 9

`endif

//--- logic/gcf_pkg.sv
// Types of the commissioning frame builder
`default_nettype none

package gcf_pkg;

	// Builder sequencer states
	typedef enum logic [1:0] {
		GCF_IDLE,
		GCF_EMIT,
		GCF_LIST
	} gcf_state_e;

	// Complete state of the builder
	typedef struct packed {
		gcf_state_e st;        // Sequencer state
		logic [5:0] idx;       // Byte position within the frame
		logic decom;           // Frame is a decommissioning frame
		logic lrn_q;           // Learn button of the previous cycle
		logic [7:0] dev_id;    // Selected device ID
		logic app_off;         // Application information switched off
		logic [7:0] sw_cfg;    // Generic switch configuration byte
		logic [63:0] cmd_tab;  // Command table, entry 0 lowest
		logic [7:0] contact;   // Current contact snapshot
		logic [2:0] ent;       // Command table walk position
		logic [3:0] remain;    // Command identifiers still to send
		logic [31:0] seq;      // Sequence counter
		logic [31:0] seq_tx;   // Counter value carried by this frame
		logic [127:0] key2;    // Second security key
		logic [127:0] lfsr;    // Random source
		logic busy;            // Frame under way
		logic [7:0] out_data;  // Output byte
		logic out_last;        // Output byte ends the frame
		logic out_valid;       // Output byte valid
	} gcf_core_s;

endpackage : gcf_pkg

`default_nettype wire

//--- logic/gcf_fifo.sv
// Byte FIFO between the frame builder and the radio transmit path
`default_nettype none

module gcf_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic mclk,                // System clock
	input wire logic rst_n,               // Synchronous reset, active low
	input wire logic in_valid,            // Write word offered
	output logic in_ready,                // Room for a word
	input wire logic [WIDTH-1:0] in_data, // Word to write
	output logic out_valid,               // Word available
	input wire logic out_ready,           // Reader takes the word
	output logic [WIDTH-1:0] out_data     // Oldest word
);

	localparam int AW = $clog2(DEPTH);

	// Whole FIFO state: storage and wrapping pointers
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage
		logic [AW:0] wp;                  // Write pointer, extra wrap bit
		logic [AW:0] rp;                  // Read pointer, extra wrap bit
	} gcf_fifo_s;

	gcf_fifo_s f_reg; // Registered state
	gcf_fifo_s f_next; // Next state
	logic full; // All words taken
	logic empty; // No word held

	// Full when pointers differ only in the wrap bit
	assign full = (f_reg.wp[AW] != f_reg.rp[AW]) && (f_reg.wp[AW-1:0] == f_reg.rp[AW-1:0]);
	assign empty = (f_reg.wp == f_reg.rp);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = f_reg.mem[f_reg.rp[AW-1:0]];

	// Write and read handling, both may happen in one cycle
	always_comb begin
		f_next = f_reg;
		if (in_valid && !full) begin
			f_next.mem[f_reg.wp[AW-1:0]] = in_data;
			f_next.wp = f_reg.wp + (AW + 1)'(1);
		end
		if (out_ready && !empty) begin
			f_next.rp = f_reg.rp + (AW + 1)'(1);
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			f_reg <= '0;
		end else begin
			f_reg <= f_next;
		end
	end

endmodule : gcf_fifo

`default_nettype wire

//--- logic/gcf_frame_builder.sv
// Commissioning and decommissioning frame builder with byte stream output
`default_nettype none
`include "gcf_cfg.svh"

module gcf_frame_builder import gcf_pkg::*; (
	input wire logic mclk,                            // System clock, 50 MHz
	input wire logic rst_n,                           // Synchronous reset, active low
	input wire logic learn_button,                    // Learn button, high while pressed
	input wire logic cfg_commission_req,              // Commissioning request pulse
	input wire logic cfg_decommission_req,            // Decommissioning request pulse
	input wire logic data_telegram_sent,              // A data telegram left, pulse
	input wire logic aux_input_a,                     // Input A grounded when high
	input wire logic aux_input_b,                     // Input B grounded when high
	input wire logic cfg_dev_id_we,                   // Device ID write strobe
	input wire logic [7:0] cfg_dev_id,                // Device ID to write
	input wire logic cfg_app_info_off_we,             // Info switch write strobe
	input wire logic cfg_app_info_off,                // One switches info off, except for device 07
	input wire logic cfg_switch_cfg_we,               // Switch configuration write strobe
	input wire logic [7:0] cfg_switch_cfg,            // Switch configuration to write
	input wire logic command_table_entry_we,          // Command entry write strobe
	input wire logic [2:0] command_table_entry_idx,   // Command entry index
	input wire logic [7:0] command_table_entry_data,  // Command entry value
	input wire logic [31:0] source_address,           // Source address, sent low byte first
	input wire logic [127:0] encrypted_key,           // Encrypted key, sent low byte first
	input wire logic [31:0] key_hash,                 // Key hash, sent low byte first
	input wire logic [31:0] auth_signature,           // Signature, sent low byte first
	input wire logic tx_ready,                        // Radio path takes a byte
	output logic tx_valid,                            // Byte offered to the radio path
	output logic [7:0] tx_data,                       // Byte of the frame
	output logic tx_last,                             // Byte ends the frame
	output logic busy,                                // Frame being built
	output logic [31:0] sequence_counter,             // Sequence counter
	output logic [127:0] second_security_key          // Second security key
);

	gcf_core_s r_reg; // Registered state
	gcf_core_s r_next; // Next state
	logic fifo_in_ready; // Buffer has room
	logic fifo_out_valid; // Buffer holds a byte
	logic fifo_out_ready; // Output stage takes a byte
	logic [8:0] fifo_out_data; // Buffered byte with end flag
	logic push; // Byte written into the buffer
	logic [7:0] push_byte; // Byte to write
	logic push_last; // Written byte ends the frame
	logic [7:0] fbyte; // Byte at the current position
	logic flast; // Current position ends the frame
	logic is_dev07; // Default device selected
	logic app_en; // Application information sent
	logic [3:0] active_cnt; // Active command table entries
	logic [1:0] k4; // Byte within a four byte field
	logic [3:0] k16; // Byte within the key field
	logic [7:0] cur_entry; // Command table entry under the walk
	logic finish; // Frame completes this cycle

	// Output stage refills whenever empty or being drained
	assign fifo_out_ready = !r_reg.out_valid || tx_ready;

	// Byte buffer between builder and radio path
	gcf_fifo #(
		.WIDTH(`GCF_FIFO_WIDTH),
		.DEPTH(`GCF_FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({push_last, push_byte}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// Outputs straight from the state register
	assign tx_valid = r_reg.out_valid;
	assign tx_data = r_reg.out_data;
	assign tx_last = r_reg.out_last;
	assign busy = r_reg.busy;
	assign sequence_counter = r_reg.seq;
	assign second_security_key = r_reg.key2;

	// Device kind and presence of application information
	always_comb begin
		is_dev07 = (r_reg.dev_id == `GCF_DEVID_DEFAULT);
		// info off only for other devices
		app_en = !(r_reg.app_off && !is_dev07);
	end

	// Count of table entries that are not inactive
	always_comb begin
		active_cnt = 4'h0;
		for (int i = 0; i < 8; i++) begin
			active_cnt = active_cnt + {3'h0, (r_reg.cmd_tab[i*8 +: 8] != `GCF_CMD_INACTIVE)};
		end
	end

	// Byte offsets within multi byte fields
	always_comb begin
		k4 = 2'h0;
		k16 = 4'h0;
		cur_entry = r_reg.cmd_tab[8*r_reg.ent +: 8];
		if (r_reg.idx < `GCF_IDX_CMD) begin
			// Source address follows the two control bytes
			k4 = 2'(r_reg.idx - `GCF_IDX_SRC);
		end else if (r_reg.decom) begin
			// Counter then signature
			k4 = (r_reg.idx < `GCF_DIDX_CMD) ? 2'(r_reg.idx - `GCF_DIDX_SEQ)
				: 2'(r_reg.idx - `GCF_DIDX_SIG);
		end else if (r_reg.idx < `GCF_IDX_SEQ) begin
			// Key hash
			k4 = 2'(r_reg.idx - `GCF_IDX_HASH);
		end else begin
			// Sequence counter
			k4 = 2'(r_reg.idx - `GCF_IDX_SEQ);
		end
		k16 = 4'(r_reg.idx - `GCF_IDX_KEY);
	end

	// Byte at the current frame position and whether it is the last
	always_comb begin
		fbyte = 8'h00;
		flast = 1'b0;
		if (r_reg.idx == 6'd0) begin
			fbyte = `GCF_FRAME_CTRL;
		end else if (r_reg.idx == 6'd1) begin
			fbyte = `GCF_EXT_FRAME_CTRL;
		end else if (r_reg.idx < `GCF_HDR_LEN) begin
			fbyte = source_address[8*k4 +: 8];
		end else if (r_reg.decom) begin
			if (r_reg.idx < `GCF_DIDX_CMD) begin
				fbyte = r_reg.seq_tx[8*k4 +: 8];
			end else if (r_reg.idx == `GCF_DIDX_CMD) begin
				fbyte = `GCF_CMD_DECOMMISSION;
			end else begin
				fbyte = auth_signature[8*k4 +: 8];
			end
			flast = (r_reg.idx == `GCF_DIDX_LAST);
		end else begin
			// Position ranges overlap, so the first match decides
			priority case (1'b1)
				(r_reg.idx == `GCF_IDX_CMD): fbyte = `GCF_CMD_COMMISSION;
				(r_reg.idx == `GCF_IDX_DEVID): fbyte = r_reg.dev_id;
				(r_reg.idx == `GCF_IDX_OPT): begin
					fbyte = app_en ? `GCF_OPT_APP_INFO : `GCF_OPT_NO_APP_INFO;
				end
				(r_reg.idx == `GCF_IDX_EXTOPT): fbyte = `GCF_EXT_OPTIONS;
				(r_reg.idx < `GCF_IDX_HASH): fbyte = encrypted_key[8*k16 +: 8];
				(r_reg.idx < `GCF_IDX_SEQ): fbyte = key_hash[8*k4 +: 8];
				(r_reg.idx <= `GCF_IDX_SEQ_END): begin
					fbyte = r_reg.seq_tx[8*k4 +: 8];
					flast = (r_reg.idx == `GCF_IDX_SEQ_END) && !app_en;
				end
				(r_reg.idx == `GCF_IDX_AI_TYPE): begin
					// switch info type; command list type
					fbyte = is_dev07 ? `GCF_AI_TYPE_SWITCH : `GCF_AI_TYPE_CMDLIST;
				end
				(r_reg.idx == `GCF_IDX_AI_LEN): begin
					fbyte = is_dev07 ? `GCF_AI_LEN_SWITCH : {4'h0, r_reg.remain};
					flast = !is_dev07 && (r_reg.remain == 4'h0);
				end
				(r_reg.idx == `GCF_IDX_SWCFG): fbyte = r_reg.sw_cfg;
				default: begin
					// contact byte closes the switch info
					fbyte = r_reg.contact;
					flast = 1'b1;
				end
			endcase
		end
	end

	// Sequencer, configuration and counters
	always_comb begin
		r_next = r_reg;
		push = 1'b0;
		push_byte = 8'h00;
		push_last = 1'b0;
		finish = 1'b0;
		r_next.lrn_q = learn_button;
		// Random source steps every cycle
		r_next.lfsr = {r_reg.lfsr[126:0],
			r_reg.lfsr[127] ^ r_reg.lfsr[125] ^ r_reg.lfsr[100] ^ r_reg.lfsr[98]};
		if (data_telegram_sent) begin
			r_next.seq = r_reg.seq + 32'h1;
		end
		// Output stage loads from the buffer or empties
		if (fifo_out_ready) begin
			r_next.out_valid = fifo_out_valid;
			if (fifo_out_valid) begin
				r_next.out_data = fifo_out_data[7:0];
				r_next.out_last = fifo_out_data[8];
			end
		end
		unique case (r_reg.st)
			GCF_IDLE: begin
				// Configuration is taken only between frames
				if (cfg_dev_id_we) begin
					r_next.dev_id = cfg_dev_id;
				end
				if (cfg_app_info_off_we) begin
					r_next.app_off = cfg_app_info_off;
				end
				if (cfg_switch_cfg_we) begin
					r_next.sw_cfg = cfg_switch_cfg;
				end
				if (command_table_entry_we) begin
					r_next.cmd_tab[8*command_table_entry_idx +: 8] = command_table_entry_data;
				end
				r_next.idx = 6'd0;
				r_next.ent = 3'd0;
				r_next.remain = active_cnt;
				r_next.seq_tx = r_reg.seq;
				r_next.contact = {5'h00, aux_input_b, aux_input_a, !(aux_input_a || aux_input_b)};
				if (cfg_decommission_req) begin
					r_next.decom = 1'b1;
					r_next.st = GCF_EMIT;
					r_next.busy = 1'b1;
				end else if (cfg_commission_req || (learn_button && !r_reg.lrn_q)) begin
					r_next.decom = 1'b0;
					r_next.st = GCF_EMIT;
					r_next.busy = 1'b1;
				end
			end
			GCF_EMIT: begin
				// one byte per buffer slot, in order
				if (fifo_in_ready) begin
					push = 1'b1;
					push_byte = fbyte;
					push_last = flast;
					if (flast) begin
						finish = 1'b1;
					end else if (!r_reg.decom && !is_dev07 && (r_reg.idx == `GCF_IDX_AI_LEN)) begin
						r_next.st = GCF_LIST;
					end else begin
						r_next.idx = r_reg.idx + 6'd1;
					end
				end
			end
			GCF_LIST: begin
				if (cur_entry == `GCF_CMD_INACTIVE) begin
					r_next.ent = r_reg.ent + 3'd1;
				end else if (fifo_in_ready) begin
					push = 1'b1;
					push_byte = cur_entry;
					push_last = (r_reg.remain == 4'h1);
					r_next.ent = r_reg.ent + 3'd1;
					r_next.remain = r_reg.remain - 4'h1;
					finish = (r_reg.remain == 4'h1);
				end
			end
		endcase
		// Frame complete: back to idle, count the telegram
		if (finish) begin
			r_next.st = GCF_IDLE;
			r_next.busy = 1'b0;
			r_next.seq = r_reg.seq + (data_telegram_sent ? 32'h2 : 32'h1);
			if (r_reg.decom) begin
				r_next.key2 = r_reg.lfsr;
			end
		end
	end

	// State register with reset values
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r_reg <= '0;
			r_reg.st <= GCF_IDLE;
			r_reg.dev_id <= `GCF_DEVID_DEFAULT;
			r_reg.sw_cfg <= `GCF_SWCFG_DEFAULT;
			r_reg.cmd_tab <= `GCF_CMD_TABLE_DEFAULT;
			r_reg.seq <= `GCF_SEQ_RST;
			r_reg.key2 <= `GCF_KEY2_RST;
			r_reg.lfsr <= `GCF_LFSR_SEED;
			r_reg.lrn_q <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

endmodule : gcf_frame_builder

`default_nettype wire

//--- sim/gcf_radio_sink.sv
// Radio transmit path model: collects frame bytes, can accept slowly
`default_nettype none

module gcf_radio_sink (
	input wire logic mclk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic stall, // Slow acceptance when high
	input wire logic tx_valid, // Byte offered
	input wire logic [7:0] tx_data, // Byte of the frame
	input wire logic tx_last, // Byte ends the frame
	output logic tx_ready // Byte taken at this edge
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$]; // Bytes received so far
	int frames = 0; // Frames completed
	logic [1:0] ph_reg; // Stall phase

	// Take every byte, or one cycle in four while stalling
	assign tx_ready = !stall || (ph_reg == 2'h3);

	// Collect bytes and count frame ends
	always @(posedge mclk) begin
		if (!rst_n) begin
			ph_reg <= 2'h0;
			frames <= 0;
		end else begin
			ph_reg <= ph_reg + 2'h1;
			if (tx_valid && tx_ready) begin
				got.push_back(tx_data);
				if (tx_last) begin
					frames <= frames + 1;
				end
			end
		end
	end
endmodule : gcf_radio_sink

`default_nettype wire

//--- sim/gcf_frame_builder_assertions.sv
// Port checker of the commissioning frame builder
`default_nettype none

module gcf_frame_builder_assertions (
	input wire logic mclk, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic learn_button, // Learn button
	input wire logic cfg_commission_req, // Commissioning request
	input wire logic cfg_decommission_req, // Decommissioning request
	input wire logic data_telegram_sent, // Data telegram pulse
	input wire logic tx_ready, // Radio path takes a byte
	input wire logic tx_valid, // Byte offered
	input wire logic [7:0] tx_data, // Byte of the frame
	input wire logic tx_last, // Byte ends the frame
	input wire logic busy, // Frame being built
	input wire logic [31:0] sequence_counter, // Sequence counter
	input wire logic [127:0] second_security_key // Second key
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire logic hs = tx_valid && tx_ready; // Byte handed over
	logic [5:0] pos_reg; // Byte position in the outgoing frame
	logic com_reg; // Outgoing frame is commissioning
	logic dev7_reg; // Outgoing frame names device 07
	logic decom_reg; // Last frame started was decommissioning

	// Track frame position and kind at the output
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pos_reg <= 6'h0;
			com_reg <= 1'b0;
			dev7_reg <= 1'b0;
			decom_reg <= 1'b0;
		end else begin
			if (!busy) begin
				decom_reg <= cfg_decommission_req;
			end
			if (hs) begin
				pos_reg <= tx_last ? 6'h0 : pos_reg + 6'h1;
				if (pos_reg == 6'h6) begin
					com_reg <= (tx_data == 8'he0);
				end
				if (pos_reg == 6'h7) begin
					dev7_reg <= (tx_data == 8'h07);
				end
			end
		end
	end

	AST_START_BUSY: assert property (!busy && (cfg_commission_req || cfg_decommission_req)
		|=> busy) else $error("request while idle did not start a frame");
	AST_NO_LEVEL_START: assert property (!busy && !cfg_commission_req &&
		!cfg_decommission_req && !$rose(learn_button) |=> !busy)
		else $error("frame started without a trigger");
	AST_HEADER: assert property (hs && pos_reg < 6'h2 |->
		tx_data == ((pos_reg == 6'h0) ? 8'h8c : 8'h30)) else $error("bad header byte");
	AST_EXT_OPTIONS: assert property (hs && com_reg && pos_reg == 6'h9 |->
		tx_data == 8'hf2) else $error("bad extended options");
	AST_AI_TYPE: assert property (hs && com_reg && pos_reg == 6'h22 |->
		tx_data == (dev7_reg ? 8'h10 : 8'h04)) else $error("bad info type");
	AST_CONTACT: assert property (hs && com_reg && dev7_reg && pos_reg == 6'h25 |->
		tx_last && tx_data[7:3] == 5'h0 && tx_data[0] == !(tx_data[1] || tx_data[2]))
		else $error("bad contact byte");
	AST_DECOM_CMD: assert property (hs && !com_reg && pos_reg == 6'ha |->
		tx_data == 8'he1) else $error("bad decommissioning command");
	AST_FRAME_LEN: assert property (hs && tx_last |->
		(!com_reg && pos_reg == 6'he) || (com_reg && pos_reg >= 6'h21))
		else $error("frame ends at wrong byte");
	AST_HOLD: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("byte dropped");
	AST_SEQ_DATA: assert property (data_telegram_sent ##1 !$fell(busy) |->
		sequence_counter == $past(sequence_counter) + 32'h1) else $error("counter step");
	AST_SEQ_FRAME: assert property ($fell(busy) |-> sequence_counter ==
		$past(sequence_counter) + 32'h1 + $past(data_telegram_sent))
		else $error("counter not advanced at frame end");
	AST_KEY_KEEP: assert property (!$fell(busy) |-> $stable(second_security_key))
		else $error("key changed outside a frame end");
	AST_KEY_RENEW: assert property ($fell(busy) && decom_reg |->
		second_security_key != $past(second_security_key)) else $error("key not renewed");

	// Main scenarios seen
	COV_SWITCH: cover property (hs && tx_last && com_reg && dev7_reg);
	COV_DECOM: cover property (hs && tx_last && !com_reg);
	COV_STALL: cover property (tx_valid && !tx_ready);
endmodule : gcf_frame_builder_assertions

bind gcf_frame_builder gcf_frame_builder_assertions i_gcf_frame_builder_assertions (
	.mclk(mclk), .rst_n(rst_n), .learn_button(learn_button),
	.cfg_commission_req(cfg_commission_req), .cfg_decommission_req(cfg_decommission_req),
	.data_telegram_sent(data_telegram_sent), .tx_ready(tx_ready), .tx_valid(tx_valid),
	.tx_data(tx_data), .tx_last(tx_last), .busy(busy), .sequence_counter(sequence_counter),
	.second_security_key(second_security_key));

`default_nettype wire

//--- sim/gcf_frame_builder_test.sv
// Self-checking bench of the commissioning frame builder
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module gcf_frame_builder_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst_n = 1'b0, learn_button = 1'b0, stall = 1'b0;
	logic cfg_commission_req = 1'b0, cfg_decommission_req = 1'b0, data_telegram_sent = 1'b0;
	logic aux_input_a = 1'b0, aux_input_b = 1'b0, cfg_dev_id_we = 1'b0, cfg_switch_cfg_we = 1'b0;
	logic cfg_app_info_off_we = 1'b0, cfg_app_info_off = 1'b0, command_table_entry_we = 1'b0;
	logic [7:0] cfg_dev_id = 8'h07, cfg_switch_cfg = 8'h01, command_table_entry_data = 8'h00;
	logic [2:0] command_table_entry_idx = 3'h0;
	// Source address value is arbitrary
	logic [31:0] source_address = 32'ha1b2c3d4, key_hash = 32'h9a8b7c6d;
	logic [31:0] auth_signature = 32'h5e6f7a8b, seq = 32'h0, sequence_counter;
	logic [127:0] encrypted_key = 128'h00112233_44556677_8899aabb_ccddeeff;
	logic [127:0] second_security_key, old_key;
	logic tx_ready, tx_valid, tx_last, busy;
	logic [7:0] tx_data;
	logic [7:0] tab[8] = '{8'h22, 8'h23, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
	logic [7:0] exp_q[$]; // Expected frame bytes
	int errors = 0, checks = 0;

	// 50 MHz clock
	initial begin
		forever #10 mclk = ~mclk;
	end

	gcf_frame_builder i_gcf_frame_builder (.mclk(mclk), .rst_n(rst_n),
		.learn_button(learn_button), .cfg_commission_req(cfg_commission_req),
		.cfg_decommission_req(cfg_decommission_req), .data_telegram_sent(data_telegram_sent),
		.aux_input_a(aux_input_a), .aux_input_b(aux_input_b), .cfg_dev_id_we(cfg_dev_id_we),
		.cfg_dev_id(cfg_dev_id), .cfg_app_info_off_we(cfg_app_info_off_we),
		.cfg_app_info_off(cfg_app_info_off), .cfg_switch_cfg_we(cfg_switch_cfg_we),
		.cfg_switch_cfg(cfg_switch_cfg), .command_table_entry_we(command_table_entry_we),
		.command_table_entry_idx(command_table_entry_idx),
		.command_table_entry_data(command_table_entry_data), .source_address(source_address),
		.encrypted_key(encrypted_key), .key_hash(key_hash), .auth_signature(auth_signature),
		.tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
		.busy(busy), .sequence_counter(sequence_counter),
		.second_security_key(second_security_key));

	gcf_radio_sink i_gcf_radio_sink (.mclk(mclk), .rst_n(rst_n), .stall(stall),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

	// Print counts and verdict, end the run
	task automatic tally_and_finish();
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Queue n bytes of v, low byte first
	task automatic put(input logic [127:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(v[8*i +: 8]);
		end
	endtask : put

	// Expected commissioning frame for the current counter and table
	task automatic build_com(input logic [7:0] dev, input logic off, input logic [7:0] sw,
		input logic [7:0] ct);
		logic [7:0] n;
		n = 8'h0;
		exp_q.delete();
		put({source_address, 8'h30, 8'h8c}, 6);
		put({8'hf2, (off && dev != 8'h07) ? 8'h81 : 8'h85, dev, 8'he0}, 4);
		put(encrypted_key, 16);
		put(key_hash, 4);
		put(seq, 4);
		if (dev == 8'h07) begin
			put({ct, sw, 8'h02, 8'h10}, 4);
		end else if (!off) begin
			foreach (tab[i]) n += (tab[i] != 8'hff);
			put({n, 8'h04}, 2);
			foreach (tab[i]) if (tab[i] != 8'hff) exp_q.push_back(tab[i]);
		end
	endtask : build_com

	// Wait for a frame end, compare it whole, then the counter
	task automatic check_frame();
		int t;
		t = 0;
		while (i_gcf_radio_sink.frames == 0 && t < 3000) begin
			@(posedge mclk);
			#1;
			t++;
		end
		if (t == 3000) begin
			errors++;
			tally_and_finish();
		end
		`CHK(i_gcf_radio_sink.got.size(), exp_q.size())
		foreach (exp_q[i]) `CHK(i_gcf_radio_sink.got[i], exp_q[i])
		i_gcf_radio_sink.got.delete();
		i_gcf_radio_sink.frames = 0;
		seq++;
		`CHK(sequence_counter, seq)
	endtask : check_frame

	// Request start, slow radio, config write refused while busy
	task automatic s_default();
		@(posedge mclk);
		stall <= 1'b1;
		aux_input_a <= 1'b1;
		cfg_commission_req <= 1'b1;
		@(posedge mclk);
		cfg_commission_req <= 1'b0;
		cfg_dev_id_we <= 1'b1;
		cfg_dev_id <= 8'h05;
		@(posedge mclk);
		cfg_dev_id_we <= 1'b0;
		build_com(8'h07, 1'b0, 8'h01, 8'h02);
		check_frame();
	endtask : s_default

	// Learn edge start, data telegram count, switch config, held button
	task automatic s_learn();
		@(posedge mclk);
		stall <= 1'b0;
		cfg_switch_cfg_we <= 1'b1;
		cfg_switch_cfg <= 8'h03;
		data_telegram_sent <= 1'b1;
		aux_input_b <= 1'b1;
		@(posedge mclk);
		cfg_switch_cfg_we <= 1'b0;
		data_telegram_sent <= 1'b0;
		learn_button <= 1'b1;
		seq++;
		build_com(8'h07, 1'b0, 8'h03, 8'h06);
		check_frame();
		repeat (5) @(posedge mclk);
		`CHK(busy, 1'b0)
		@(posedge mclk);
		learn_button <= 1'b0;
		aux_input_a <= 1'b0;
		aux_input_b <= 1'b0;
		@(posedge mclk);
		learn_button <= 1'b1;
		build_com(8'h07, 1'b0, 8'h03, 8'h01);
		check_frame();
	endtask : s_learn

	// Write one command table entry, strobe left high
	task automatic put_entry(input logic [2:0] idx, input logic [7:0] d);
		@(posedge mclk);
		command_table_entry_we <= 1'b1;
		command_table_entry_idx <= idx;
		command_table_entry_data <= d;
		tab[idx] = d;
	endtask : put_entry

	// Command list with defaults, then overrides and inactive entries
	task automatic s_list();
		@(posedge mclk);
		learn_button <= 1'b0;
		cfg_dev_id_we <= 1'b1;
		cfg_dev_id <= 8'h02;
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk);
			cfg_dev_id_we <= 1'b0;
			command_table_entry_we <= 1'b0;
			cfg_commission_req <= 1'b1;
			@(posedge mclk);
			cfg_commission_req <= 1'b0;
			build_com(8'h02, 1'b0, 8'h03, 8'h06);
			check_frame();
			put_entry(3'h0, 8'h40);
			put_entry(3'h1, 8'hff);
			put_entry(3'h7, 8'hff);
		end
	endtask : s_list

	// Info switched off: short frame, other options value
	task automatic s_info_off();
		@(posedge mclk);
		command_table_entry_we <= 1'b0;
		cfg_app_info_off_we <= 1'b1;
		cfg_app_info_off <= 1'b1;
		@(posedge mclk);
		cfg_app_info_off_we <= 1'b0;
		cfg_commission_req <= 1'b1;
		@(posedge mclk);
		cfg_commission_req <= 1'b0;
		build_com(8'h02, 1'b1, 8'h03, 8'h06);
		check_frame();
	endtask : s_info_off

	// Decommissioning wins over a same-edge request and renews the key
	task automatic s_decom();
		old_key = second_security_key;
		@(posedge mclk);
		cfg_decommission_req <= 1'b1;
		cfg_commission_req <= 1'b1;
		@(posedge mclk);
		cfg_decommission_req <= 1'b0;
		cfg_commission_req <= 1'b0;
		exp_q.delete();
		put({seq, source_address, 8'h30, 8'h8c}, 10);
		put({auth_signature, 8'he1}, 5);
		check_frame();
		`CHK(second_security_key !== old_key, 1'b1)
	endtask : s_decom

	// Reset for two cycles, then the scenarios
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		s_default();
		s_learn();
		s_list();
		s_info_off();
		s_decom();
		tally_and_finish();
	end
endmodule : gcf_frame_builder_test

`default_nettype wire
